// ===== sfm_fault_monitor.sv
// Top of the servo fault monitor: condition checks, latching and code report.
`timescale 1ns/10ps
`default_nettype none
module sfm_fault_monitor #(
   parameter int NUM_DI = 8,
   parameter int NUM_VDI = 8,
   parameter int TEMP_W = 12,
   parameter int SPD_W = 16,
   parameter int POS_W = 32,
   parameter int ENC_W = 4
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic encoderLearning,
   input wire logic [sfm_pkg::HALL_W-1:0] hallCode,
   input wire logic wireSavingEncoder,
   input wire logic powerOnCheck,
   input wire logic [TEMP_W-1:0] driveTemperatureReading,
   input wire logic [TEMP_W-1:0] overheatThreshold,
   input wire logic [ENC_W-1:0] encoderTypeSetting,
   input wire logic [ENC_W-1:0] logicVersionEncoderKind,
   input wire logic homingNeedsSwitch,
   input wire logic [sfm_pkg::FN_W-1:0] digitalInputFunc [NUM_DI],
   input wire logic [sfm_pkg::FN_W-1:0] virtualInputFunc [NUM_VDI],
   input wire logic fixedLengthEnable,
   input wire logic signed [SPD_W-1:0] actualSpeed,
   input wire logic [SPD_W-1:0] ratedSpeed,
   input wire logic [SPD_W-1:0] overspeedPercent,
   input wire logic signed [POS_W-1:0] positionErrorValue,
   input wire logic [POS_W-1:0] positionErrorThreshold,
   input wire logic homeComplete,
   input wire logic absoluteModeStart,
   input wire logic faultClear,
   output logic faultActive_r,
   output logic [sfm_pkg::CODE_W-1:0] faultCode_r,
   output logic [sfm_pkg::NUM_FAULTS-1:0] faultFlags_r,
   output logic homed_r
);

   localparam int NUM_TERM = NUM_DI + NUM_VDI;
   localparam int PROD_W = 2 * SPD_W;

   // Terminal map: physical terminals first, virtual ones after them.
   sfm_map_if #(.NUM_TERM(NUM_TERM)) mapBus ();

   always_comb begin
      for (int i = 0; i < NUM_DI; i++) begin
         mapBus.funcNum[i] = digitalInputFunc[i];
      end
      for (int k = 0; k < NUM_VDI; k++) begin
         mapBus.funcNum[NUM_DI + k] = virtualInputFunc[k];
      end
   end

   sfm_map_scan #(.NUM_TERM(NUM_TERM)) mapScan (
      .map(mapBus.scanner)
   );

   // Magnitudes and scaled products for the speed and position checks.
   logic [SPD_W-1:0] speedMag;
   logic [POS_W-1:0] posErrMag;
   logic [PROD_W-1:0] speedScaled;
   logic [PROD_W-1:0] speedLimit;

   // Magnitudes are taken so that reverse motion is judged like forward motion.
   always_comb begin
      speedMag = actualSpeed[SPD_W-1] ? SPD_W'(-actualSpeed) : SPD_W'(actualSpeed);
      posErrMag = positionErrorValue[POS_W-1] ? POS_W'(-positionErrorValue)
                                              : POS_W'(positionErrorValue);
      // Cross-multiplying avoids a divider: speed*100 > rated*limit.
      speedScaled = PROD_W'(speedMag) * PROD_W'(sfm_pkg::PERCENT_SCALE);
      speedLimit = PROD_W'(ratedSpeed) * PROD_W'(overspeedPercent);
   end

   // Raw condition vector, one bit per fault, evaluated every cycle.
   logic [sfm_pkg::NUM_FAULTS-1:0] cond;

   always_comb begin
      cond = sfm_pkg::FLAGS_CLEAR;
      cond[sfm_pkg::FB_HALL_LEARN] = encoderLearning &&
         (hallCode == sfm_pkg::HALL_ALL_ZERO || hallCode == sfm_pkg::HALL_ALL_ONE); // see [R1]
      cond[sfm_pkg::FB_OVERHEAT] = driveTemperatureReading > overheatThreshold; // see [R2]
      cond[sfm_pkg::FB_HALL_POWERON] = powerOnCheck && wireSavingEncoder &&
         (hallCode == sfm_pkg::HALL_ALL_ZERO || hallCode == sfm_pkg::HALL_ALL_ONE); // see [R3]
      cond[sfm_pkg::FB_ENC_MISMATCH] = logicVersionEncoderKind != encoderTypeSetting; // see [R4]
      cond[sfm_pkg::FB_HOME_UNASSIGNED] = homingNeedsSwitch && !mapBus.homeAssigned; // see [R5]
      cond[sfm_pkg::FB_DUPLICATE] = mapBus.duplicate; // see [R6]
      cond[sfm_pkg::FB_OVERSPEED] = speedScaled > speedLimit; // see [R7]
      cond[sfm_pkg::FB_POS_ERROR] = posErrMag > positionErrorThreshold; // see [R8]
      cond[sfm_pkg::FB_TRIG_UNASSIGNED] = fixedLengthEnable && !mapBus.trigAssigned; // see [R9]
      cond[sfm_pkg::FB_NOT_HOMED] = absoluteModeStart && !homed_r && !homeComplete; // see [R10]
   end

   // Next values of the fault latch, the shown code and the homed flag.
   logic [sfm_pkg::NUM_FAULTS-1:0] faultFlags_nxt;
   logic [sfm_pkg::CODE_W-1:0] faultCode_nxt;
   logic faultActive_nxt;
   logic homed_nxt;
   logic [sfm_pkg::CODE_W-1:0] newCode;

   // The lowest-numbered new fault wins when several appear together.
   always_comb begin
      newCode = sfm_pkg::CODE_NONE;
      for (int f = sfm_pkg::NUM_FAULTS - 1; f >= 0; f--) begin
         if (cond[f]) begin
            newCode = sfm_pkg::sfm_code_of(f);
         end
      end
   end

   // A clear drops old faults, but a condition present in the same cycle is kept.
   always_comb begin
      if (faultClear) begin
         faultFlags_nxt = cond; // see [R11]
         faultCode_nxt = newCode; // see [R11]
      end else begin
         faultFlags_nxt = faultFlags_r | cond; // see [R11]
         if (faultCode_r == sfm_pkg::CODE_NONE) begin
            faultCode_nxt = newCode;
         end else begin
            faultCode_nxt = faultCode_r; // The first fault raised stays on display.
         end
      end
      faultActive_nxt = |faultFlags_nxt;
      // Homed is remembered until reset; only a fresh power-up forgets it.
      homed_nxt = homed_r | homeComplete; // see [R10]
   end

   // State registers of the monitor.
   always_ff @(posedge clock) begin
      if (reset) begin
         faultFlags_r <= sfm_pkg::FLAGS_CLEAR;
         faultCode_r <= sfm_pkg::CODE_NONE;
         faultActive_r <= 1'b0;
         homed_r <= 1'b0;
      end else begin
         faultFlags_r <= faultFlags_nxt;
         faultCode_r <= faultCode_nxt;
         faultActive_r <= faultActive_nxt;
         homed_r <= homed_nxt;
      end
   end

endmodule : sfm_fault_monitor
`default_nettype wire

// ===== sfm_fault_monitor_properties.sv
// Concurrent checks on the ports of the servo fault monitor.
`timescale 1ns/10ps
`default_nettype none
module sfm_fault_monitor_properties #(
   parameter int TEMP_W = 12,
   parameter int ENC_W = 4
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic encoderLearning,
   input wire logic [sfm_pkg::HALL_W-1:0] hallCode,
   input wire logic wireSavingEncoder,
   input wire logic powerOnCheck,
   input wire logic [TEMP_W-1:0] driveTemperatureReading,
   input wire logic [TEMP_W-1:0] overheatThreshold,
   input wire logic [ENC_W-1:0] encoderTypeSetting,
   input wire logic [ENC_W-1:0] logicVersionEncoderKind,
   input wire logic homeComplete,
   input wire logic absoluteModeStart,
   input wire logic faultClear,
   input wire logic faultActive_r,
   input wire logic [sfm_pkg::CODE_W-1:0] faultCode_r,
   input wire logic [sfm_pkg::NUM_FAULTS-1:0] faultFlags_r,
   input wire logic homed_r
);
   // All checks share the one clock, and reset silences them.
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   property p_hot; driveTemperatureReading > overheatThreshold |=> faultFlags_r[1]; endproperty
   a_hot: assert property (p_hot) else $error("overheat flag missing");
   property p_learn; encoderLearning && (hallCode == 3'h0 || hallCode == 3'h7)
      |=> faultFlags_r[0]; endproperty
   a_learn: assert property (p_learn) else $error("hall learn flag missing");
   property p_pon; wireSavingEncoder && powerOnCheck && (hallCode == 3'h0 || hallCode == 3'h7)
      |=> faultFlags_r[2]; endproperty
   a_pon: assert property (p_pon) else $error("power-on hall flag missing");
   property p_enc; encoderTypeSetting != logicVersionEncoderKind |=> faultFlags_r[3]; endproperty
   a_enc: assert property (p_enc) else $error("encoder mismatch flag missing");
   property p_home; absoluteModeStart && !homed_r && !homeComplete |=> faultFlags_r[9]; endproperty
   a_home: assert property (p_home) else $error("not homed flag missing");
   // Flags may only fall at a clear request, so an idle cycle keeps every one.
   property p_keep; !faultClear
      |=> (faultFlags_r & $past(faultFlags_r)) == $past(faultFlags_r); endproperty
   a_keep: assert property (p_keep) else $error("flag dropped without clear");
   property p_code; faultActive_r && !faultClear |=> $stable(faultCode_r); endproperty
   a_code: assert property (p_code) else $error("shown code changed");
   property p_act; (faultActive_r == (faultFlags_r != 10'h000))
      && ((faultCode_r != 8'h00) == faultActive_r); endproperty
   a_act: assert property (p_act) else $error("active flag and code disagree");
endmodule : sfm_fault_monitor_properties
bind sfm_fault_monitor sfm_fault_monitor_properties #(.TEMP_W(TEMP_W), .ENC_W(ENC_W)) u_props (
   .clock(clock), .reset(reset), .encoderLearning(encoderLearning), .hallCode(hallCode),
   .wireSavingEncoder(wireSavingEncoder), .powerOnCheck(powerOnCheck),
   .driveTemperatureReading(driveTemperatureReading), .overheatThreshold(overheatThreshold),
   .encoderTypeSetting(encoderTypeSetting), .logicVersionEncoderKind(logicVersionEncoderKind),
   .homeComplete(homeComplete), .absoluteModeStart(absoluteModeStart), .faultClear(faultClear),
   .faultActive_r(faultActive_r), .faultCode_r(faultCode_r), .faultFlags_r(faultFlags_r),
   .homed_r(homed_r));
`default_nettype wire

// ===== sfm_fault_monitor_test.sv
// Self-checking testbench of the servo fault monitor.
`timescale 1ns/10ps
`default_nettype none
module sfm_fault_monitor_test;
   logic clock = 1'b0, reset = 1'b1, learn = 1'b0, wse = 1'b0, pon = 1'b0, hneed = 1'b0;
   logic fle = 1'b0, homeDone = 1'b0, absStart = 1'b0, clr = 1'b0;
   logic [2:0] hallSel = 3'h1, hall;
   logic [1:0] mapSel = 2'h0;
   logic [11:0] temp = 12'h000, hot = 12'h064;
   logic [3:0] encSet = 4'h1, encKind = 4'h1;
   logic signed [15:0] speed = 16'sh0000;
   logic [15:0] rated = 16'h03E8, pct = 16'h0078;
   logic signed [31:0] posErr = 32'sh00000000;
   logic [31:0] posLim = 32'h00000064;
   logic [5:0] diF [8];
   logic [5:0] vdiF [8];
   logic active, homed;
   logic [7:0] code;
   logic [9:0] flags;
   int nMismatch = 0, checkCount = 0, cycles = 0;
   sfm_terminal_model u_terms (.hallSel(hallSel), .mapSel(mapSel), .hallCode(hall),
      .diFunc(diF), .vdiFunc(vdiF));
   sfm_fault_monitor u_dut (.clock(clock), .reset(reset), .encoderLearning(learn), .hallCode(hall),
      .wireSavingEncoder(wse), .powerOnCheck(pon), .driveTemperatureReading(temp),
      .overheatThreshold(hot), .encoderTypeSetting(encSet), .logicVersionEncoderKind(encKind),
      .homingNeedsSwitch(hneed), .digitalInputFunc(diF), .virtualInputFunc(vdiF),
      .fixedLengthEnable(fle), .actualSpeed(speed), .ratedSpeed(rated), .overspeedPercent(pct),
      .positionErrorValue(posErr), .positionErrorThreshold(posLim), .homeComplete(homeDone),
      .absoluteModeStart(absStart), .faultClear(clr), .faultActive_r(active),
      .faultCode_r(code), .faultFlags_r(flags), .homed_r(homed));
   always #2.5 clock = ~clock;
   // A hang shows as a runaway cycle count; the tests need well under this ceiling.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 1000) begin
         nMismatch++;
         giveVerdict();
      end
   end
   task giveVerdict();
      $display("checks %0d mismatches %0d", checkCount, nMismatch);
      if (nMismatch == 0 && checkCount > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : giveVerdict
   // Lets one rising edge sample the inputs, then compares flags, code and active.
   task expect_out(input logic [9:0] f, input logic [7:0] c);
      @(negedge clock);
      checkCount++;
      if (flags !== f || code !== c || active !== (f != 10'h000)) begin
         nMismatch++;
         $display("wrong value at %0t: flags %h code %h", $time, flags, code);
      end
   endtask : expect_out
   // Compares the homed indication.
   task check_bit(input logic b);
      checkCount++;
      if (homed !== b) begin
         nMismatch++;
         $display("wrong value at %0t: homed %b", $time, homed);
      end
   endtask : check_bit
   // Conditions must already be gone, otherwise level faults would latch again.
   task calm();
      clr = 1'b1;
      expect_out(10'h000, 8'h00);
      clr = 1'b0;
   endtask : calm
   initial begin
      repeat (5) @(negedge clock);
      reset = 1'b0;
      check_bit(1'b0);
      temp = 12'h064;
      expect_out(10'h000, 8'h00);
      temp = 12'h065;
      expect_out(10'h002, 8'h75);
      encKind = 4'h2;
      expect_out(10'h00A, 8'h75);
      temp = 12'h000;
      learn = 1'b1;
      hallSel = 3'h0;
      clr = 1'b1;
      expect_out(10'h009, 8'h73);
      clr = 1'b0;
      hallSel = 3'h7;
      encKind = 4'h1;
      expect_out(10'h009, 8'h73);
      learn = 1'b0;
      calm();
      wse = 1'b1;
      pon = 1'b1;
      expect_out(10'h004, 8'h76);
      pon = 1'b0;
      calm();
      hneed = 1'b1;
      fle = 1'b1;
      mapSel = 2'h1;
      expect_out(10'h110, 8'hC8);
      mapSel = 2'h0;
      calm();
      mapSel = 2'h2;
      expect_out(10'h020, 8'hC9);
      mapSel = 2'h0;
      calm();
      speed = -16'sh04B0;
      posErr = -32'sh00000064;
      expect_out(10'h000, 8'h00);
      speed = -16'sh04B1;
      posErr = -32'sh00000065;
      expect_out(10'h0C0, 8'hCA);
      speed = 16'sh0000;
      posErr = 32'sh00000000;
      calm();
      encKind = 4'h3;
      expect_out(10'h008, 8'h77);
      encKind = 4'h1;
      calm();
      posErr = 32'sh00000065;
      expect_out(10'h080, 8'hCB);
      posErr = 32'sh00000000;
      calm();
      absStart = 1'b1;
      expect_out(10'h200, 8'hCD);
      absStart = 1'b0;
      calm();
      check_bit(1'b0);
      homeDone = 1'b1;
      @(negedge clock);
      homeDone = 1'b0;
      absStart = 1'b1;
      expect_out(10'h000, 8'h00);
      check_bit(1'b1);
      giveVerdict();
   end
endmodule : sfm_fault_monitor_test
`default_nettype wire

// ===== sfm_map_if.sv
// Interface between the monitor and its terminal map scanner.
`timescale 1ns/10ps
`default_nettype none
interface sfm_map_if #(
   parameter int NUM_TERM = 16
);
   // Function number held by each physical and virtual terminal.
   logic [sfm_pkg::FN_W-1:0] funcNum [NUM_TERM];
   logic homeAssigned;
   logic trigAssigned;
   logic duplicate;

   modport scanner (input funcNum, output homeAssigned, output trigAssigned, output duplicate);
   modport user (output funcNum, input homeAssigned, input trigAssigned, input duplicate);
endinterface : sfm_map_if
`default_nettype wire

// ===== sfm_map_scan.sv
// Scanner of the terminal function map: searches and duplicate check.
`timescale 1ns/10ps
`default_nettype none
module sfm_map_scan #(
   parameter int NUM_TERM = 16
) (
   sfm_map_if.scanner map
);

   // Pairwise compare of used terminals; the cost grows with the square of the count.
   always_comb begin
      map.homeAssigned = 1'b0;
      map.trigAssigned = 1'b0;
      map.duplicate = 1'b0;
      for (int i = 0; i < NUM_TERM; i++) begin
         if (map.funcNum[i] == sfm_pkg::FN_HOME_SWITCH) begin
            map.homeAssigned = 1'b1; // see [R5]
         end
         if (map.funcNum[i] == sfm_pkg::FN_FIXLEN_TRIGGER) begin
            map.trigAssigned = 1'b1; // see [R9]
         end
         for (int j = i + 1; j < NUM_TERM; j++) begin
            if (map.funcNum[i] != sfm_pkg::FN_UNUSED && map.funcNum[i] == map.funcNum[j]) begin
               map.duplicate = 1'b1; // see [R6]
            end
         end
      end
   end

endmodule : sfm_map_scan
`default_nettype wire

// ===== sfm_pkg.sv
// Constants, fault codes and types shared by the servo fault monitor.
// How it works
// [R1] While learning the encoder, a hall code of all zeros or all ones raises 115.
// [R2] Drive temperature strictly above the overheat threshold raises 117.
// [R3] At power-on with a wire-saving encoder, an invalid hall value raises 118.
// [R4] Detected encoder kind differing from the configured encoder type raises 119.
// [R5] Homing mode needing the home switch with no terminal carrying 34 raises 200.
// [R6] One input function number on two different terminals raises 201.
// [R7] Actual speed over rated speed, in percent, above the limit raises 202.
// [R8] Position error magnitude above the position error threshold raises 203.
// [R9] Fixed-length interrupt enabled with no terminal carrying 40 raises 204.
// [R10] Absolute position mode started without a home completed since power-up raises 205.
// [R11] Every raised fault stays latched until a clear request; the code of the first one raised stays shown until then.
package sfm_pkg;

   // Width of a fault code and the value shown when nothing is latched.
   localparam int CODE_W = 8;
   localparam logic [7:0] CODE_NONE = 8'h00;

   // Fault codes, one per monitored condition.
   localparam logic [7:0] CODE_HALL_LEARN = 8'h73;
   localparam logic [7:0] CODE_OVERHEAT = 8'h75;
   localparam logic [7:0] CODE_HALL_POWERON = 8'h76;
   localparam logic [7:0] CODE_ENC_MISMATCH = 8'h77;
   localparam logic [7:0] CODE_HOME_UNASSIGNED = 8'hC8;
   localparam logic [7:0] CODE_DUPLICATE = 8'hC9;
   localparam logic [7:0] CODE_OVERSPEED = 8'hCA;
   localparam logic [7:0] CODE_POS_ERROR = 8'hCB;
   localparam logic [7:0] CODE_TRIG_UNASSIGNED = 8'hCC;
   localparam logic [7:0] CODE_NOT_HOMED = 8'hCD;

   // Bit positions of the faults in the flag vector, lowest code first.
   localparam int NUM_FAULTS = 10;
   localparam int FB_HALL_LEARN = 0;
   localparam int FB_OVERHEAT = 1;
   localparam int FB_HALL_POWERON = 2;
   localparam int FB_ENC_MISMATCH = 3;
   localparam int FB_HOME_UNASSIGNED = 4;
   localparam int FB_DUPLICATE = 5;
   localparam int FB_OVERSPEED = 6;
   localparam int FB_POS_ERROR = 7;
   localparam int FB_TRIG_UNASSIGNED = 8;
   localparam int FB_NOT_HOMED = 9;

   // Input function numbers of interest; zero marks an unused terminal.
   localparam int FN_W = 6;
   localparam logic [5:0] FN_UNUSED = 6'h00;
   localparam logic [5:0] FN_HOME_SWITCH = 6'h22;
   localparam logic [5:0] FN_FIXLEN_TRIGGER = 6'h28;

   // Hall code layout and the percentage scale of the overspeed check.
   localparam int HALL_W = 3;
   localparam logic [2:0] HALL_ALL_ZERO = 3'h0;
   localparam logic [2:0] HALL_ALL_ONE = 3'h7;
   localparam logic [15:0] PERCENT_SCALE = 16'h0064;
   localparam logic [9:0] FLAGS_CLEAR = 10'h000;

   typedef logic [NUM_FAULTS-1:0] sfm_flags_t;
   typedef logic [CODE_W-1:0] sfm_code_t;

   // Maps a flag bit to its fault code.
   function automatic sfm_code_t sfm_code_of(input int idx);
      sfm_code_t c;
      c = CODE_NONE;
      case (idx)
         FB_HALL_LEARN: c = CODE_HALL_LEARN;
         FB_OVERHEAT: c = CODE_OVERHEAT;
         FB_HALL_POWERON: c = CODE_HALL_POWERON;
         FB_ENC_MISMATCH: c = CODE_ENC_MISMATCH;
         FB_HOME_UNASSIGNED: c = CODE_HOME_UNASSIGNED;
         FB_DUPLICATE: c = CODE_DUPLICATE;
         FB_OVERSPEED: c = CODE_OVERSPEED;
         FB_POS_ERROR: c = CODE_POS_ERROR;
         FB_TRIG_UNASSIGNED: c = CODE_TRIG_UNASSIGNED;
         FB_NOT_HOMED: c = CODE_NOT_HOMED;
         default: c = CODE_NONE;
      endcase
      return c;
   endfunction : sfm_code_of

endpackage : sfm_pkg

// ===== sfm_terminal_model.sv
// Behavioural model of the hall sensors and the input terminal function map.
`timescale 1ns/10ps
`default_nettype none
module sfm_terminal_model (
   input wire logic [2:0] hallSel,
   input wire logic [1:0] mapSel,
   output logic [2:0] hallCode,
   output logic [5:0] diFunc [8],
   output logic [5:0] vdiFunc [8]
);
   // Map 0 is clean, 1 is empty, 2 repeats one function.
   // Outputs follow the selects at once, since the bench moves them at the falling edge;
   // a copy clocked on that same edge would race the bench and lag by a cycle.
   always_comb begin
      hallCode = hallSel;
      for (int i = 0; i < 8; i++) begin
         diFunc[i] = 6'h00;
         vdiFunc[i] = 6'h00;
      end
      if (mapSel != 2'h1) begin
         diFunc[0] = 6'h22;
         diFunc[1] = 6'h28;
      end
      if (mapSel == 2'h2) begin
         diFunc[2] = 6'h05;
         vdiFunc[3] = 6'h05;
      end
   end
endmodule : sfm_terminal_model
`default_nettype wire
